// ---- drs_pkg.sv ----
package drs_pkg;
   // stage count and setting groups
   localparam int NUM_STAGES = 4;
   localparam int STAGE_W = 2;
   localparam int NUM_GROUPS = 8;
   localparam int GROUP_W = 3;
   localparam int WORDS_PER_SET = 4;
   localparam int MEM_DEPTH = NUM_STAGES * NUM_GROUPS * WORDS_PER_SET;
   localparam int MEM_AW = 7;
   localparam int NUM_OUTS = 3;
   localparam int OUT_START = 0;
   localparam int OUT_TRIP = 1;
   localparam int OUT_BLOCK = 2;

   // timing: clock, millisecond stamp, measurement update
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
   localparam int UPDATE_MS_INT = 5;
   localparam logic [31:0] UPDATE_MS = 32'h0000_0005;
   localparam int PREFAULT_WIN_MS = 20;
   localparam int PREFAULT_LAG_MS = 20;
   localparam int WIN_N = PREFAULT_WIN_MS / UPDATE_MS_INT;
   localparam int LAG_N = PREFAULT_LAG_MS / UPDATE_MS_INT;
   localparam int HIST_N = LAG_N + WIN_N - 1;
   localparam int WIN_SHIFT = $clog2(WIN_N);
   localparam logic [15:0] SQUELCH_DIV = 16'h0064;
   localparam logic [15:0] ANGLE_HALF = 16'h8000;

   // register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_NOMINAL = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_TIME = 12'h00c;
   localparam logic [11:0] ADDR_GEN = 12'h010;
   localparam logic [11:0] GEN_SPAN = 12'h010;
   localparam logic [11:0] ADDR_CNT = 12'h040;
   localparam logic [11:0] CNT_SPAN = 12'h040;
   localparam int CNT_STAGE_LSB = 4;
   localparam logic [11:0] ADDR_PRE = 12'h080;
   localparam logic [11:0] PRE_SPAN = 12'h010;
   localparam logic [11:0] ADDR_SET = 12'h200;
   localparam logic [11:0] SET_SPAN = 12'h200;
   localparam int WORD_LSB = 2;

   // control register bits and reset values
   localparam int CTRL_ALLOW_LN = 0;
   localparam int CTRL_FORCE_EN = 1;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] NOMINAL_RESET = 32'h0100_0100;
   localparam logic [31:0] GEN_RESET = 32'h0111_1101;

   // field codes
   localparam logic [3:0] LN_ON = 4'h1;
   localparam logic [3:0] LN_BLOCKED = 4'h2;
   localparam logic [3:0] LN_TEST_BLK = 4'h4;
   localparam logic [3:0] LN_OFF = 4'h5;
   localparam logic [3:0] FORCE_NORMAL = 4'h0;
   localparam logic [3:0] FORCE_START = 4'h1;
   localparam logic [3:0] FORCE_TRIP = 4'h2;
   localparam logic [3:0] FORCE_BLOCKED = 4'h3;
   localparam logic [3:0] FORCE_UE_START = 4'h4;
   localparam logic [3:0] FORCE_UE_TRIP = 4'h5;
   localparam logic [3:0] FORCE_CP_START = 4'h6;
   localparam logic [3:0] FORCE_CP_TRIP = 4'h7;
   localparam logic [3:0] POL_INV = 4'h2;
   localparam logic [3:0] USRC_CALC = 4'h2;
   localparam logic [3:0] USRC_U3 = 4'h3;
   localparam logic [3:0] USRC_U4 = 4'h4;
   localparam logic [3:0] MAG_TRMS = 4'h2;
   localparam logic [3:0] MAG_PP = 4'h3;
   localparam logic [3:0] SIDE_2 = 4'h2;
   localparam logic [3:0] ISRC_SENS = 4'h2;
   localparam logic [3:0] ISRC_CALC = 4'h3;
   localparam logic [3:0] MODE_INST = 4'h0;
   localparam logic [3:0] MODE_DT = 4'h1;
   localparam logic [3:0] MODE_IDMT = 4'h2;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_RD0 = 3'b001,
      SEQ_RD1 = 3'b010,
      SEQ_RD2 = 3'b011,
      SEQ_EVAL = 3'b100
   } drs_seq_t;

   // static general settings of one stage, one word
   typedef struct packed {
      logic [3:0] pad;
      logic [3:0] i_src;
      logic [3:0] side;
      logic [3:0] mag;
      logic [3:0] u_src;
      logic [3:0] pol;
      logic [3:0] force_code;
      logic [3:0] ln;
   } drs_gen_t;

   // setting-group words 0..2
   typedef struct packed {
      logic [15:0] u_set;
      logic [15:0] i_set;
   } drs_set0_t;
   typedef struct packed {
      logic [15:0] half_width;
      logic [15:0] offset;
   } drs_set1_t;
   typedef struct packed {
      logic [15:0] delay;
      logic [7:0] pad;
      logic [3:0] curve;
      logic [3:0] mode;
   } drs_set2_t;

   typedef struct packed {
      logic [15:0] c_rms;
      logic [15:0] c_trms;
      logic [15:0] c_pp;
      logic [15:0] s_rms;
      logic [15:0] s_trms;
      logic [15:0] s_pp;
      logic [15:0] calc;
      logic [15:0] c_ang;
      logic [15:0] s_ang;
      logic [15:0] calc_ang;
   } drs_side_t;

   typedef struct packed {
      drs_side_t side2;
      drs_side_t side1;
      logic [15:0] u_meas;
      logic [15:0] u_meas_ang;
      logic [15:0] u_calc;
      logic [15:0] u_calc_ang;
      logic [15:0] u3;
      logic [15:0] u3_ang;
      logic [15:0] u4;
      logic [15:0] u4_ang;
   } drs_meas_t;

   typedef struct packed {
      logic valid;
      logic [STAGE_W-1:0] stage;
      logic [NUM_OUTS-1:0] on;
      logic [NUM_OUTS-1:0] off;
      logic [31:0] stamp;
   } drs_event_t;
endpackage : drs_pkg

// ---- drs_mem.sv ----
`timescale 1ns/1ps
module drs_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   // no reset: contents are loaded by software before use
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule : drs_mem

// ---- drs_top.sv ----
// Functional notes
// - four stage instances, each with own outputs and settings
// - residual magnitude selectable: fundamental rms, true rms, peak-to-peak
// - direction from residual current angle versus neutral voltage angle
// - no trip unless neutral voltage exceeds its set level
// - eight setting groups, one common selector, changes while running
// - instant or delayed mode; delayed is definite or inverse time
// - start, trip, blocked outputs; stamped event on every edge
// - instant mode emits start and trip in one event, same stamp
// - event stamps count whole milliseconds
// - separate cumulative counters for start, trip and blocked
// - true rms value comes from the full 32-component spectrum
// - peak-to-peak value comes straight from the samples
// - angle valid only above 0.01 of nominal current and voltage
// - pre-fault: 20 ms average ending 20 ms before start or trip
// - general settings are static, untouched by group selection
// - node mode on/blocked/test/test-blocked/off, writable only when allowed
// - force field overrides stage state when forcing is enabled
// - polarity code 2 turns the voltage angle by 180 degrees
// - neutral voltage source: select, computed, third or fourth input
// - magnitude type applies only to the two physical residual inputs
// - residual source coarse, sensitive or computed; side picks module
// - pick-up raises start only while blocking is inactive
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module drs_top #(
   parameter int MS_CYCLES = drs_pkg::MS_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire drs_pkg::drs_meas_t meas_i,
   input wire logic meas_valid_i,
   input wire logic [drs_pkg::NUM_STAGES-1:0] block_i,
   input wire logic [drs_pkg::GROUP_W-1:0] sg_sel_i,
   output logic [drs_pkg::NUM_STAGES-1:0] start_o,
   output logic [drs_pkg::NUM_STAGES-1:0] trip_o,
   output logic [drs_pkg::NUM_STAGES-1:0] blocked_o,
   output drs_pkg::drs_event_t event_o
);
   import drs_pkg::*;

   typedef struct packed {
      drs_seq_t fsm;
      logic [STAGE_W-1:0] stg;
      logic [GROUP_W-1:0] sg;
      logic [NUM_STAGES-1:0] blk;
      logic [31:0] w0;
      logic [31:0] w1;
      drs_meas_t meas;
      logic [31:0] ctrl;
      logic [31:0] nominal;
      drs_gen_t [NUM_STAGES-1:0] gen;
      logic [NUM_STAGES-1:0][NUM_OUTS-1:0] outs;
      logic [NUM_STAGES-1:0][NUM_OUTS-1:0][31:0] cnt;
      logic [NUM_STAGES-1:0][15:0] pre;
      logic [NUM_STAGES-1:0][31:0] acc;
      logic [NUM_STAGES-1:0][HIST_N-1:0][15:0] hist;
      logic [31:0] ms_div;
      logic [31:0] stamp;
      drs_event_t evt;
      logic ap_valid;
      logic ap_write;
      logic [11:0] ap_addr;
      logic [1:0] rd_ph;
      logic [31:0] rdata;
   } drs_state_t;

   drs_state_t st_reg;
   drs_state_t st_next;
   logic bus_ready;
   logic ram_we;
   logic [MEM_AW-1:0] ram_waddr;
   logic [MEM_AW-1:0] ram_raddr;
   logic [31:0] ram_rdata;

   // setting groups live in ram, read back by the sequencer
   drs_mem #(
      .WIDTH(32),
      .DEPTH(MEM_DEPTH),
      .AW(MEM_AW)
   ) u_set_mem (
      .clk_i(clk_i),
      .wr_en_i(ram_we),
      .wr_addr_i(ram_waddr),
      .wr_data_i(hwdata_i),
      .rd_addr_i(ram_raddr),
      .rd_data_o(ram_rdata)
   );

   function automatic logic [15:0] pick_mag(input logic [3:0] t, input logic [15:0] rms,
                                            input logic [15:0] trms, input logic [15:0] pp);
      case (t)
         MAG_TRMS: pick_mag = trms;
         MAG_PP: pick_mag = pp;
         default: pick_mag = rms;
      endcase
   endfunction : pick_mag

   // reads stall two cycles or more, longer while the sequencer is busy; writes complete with no wait
   assign bus_ready = !(st_reg.ap_valid && !st_reg.ap_write && st_reg.rd_ph != 2'h2);

   always_comb begin
      logic [11:0] a;
      logic [11:0] off;
      logic [31:0] rv;
      drs_gen_t gw;
      drs_gen_t g;
      drs_set0_t s0;
      drs_set1_t s1;
      drs_set2_t s2;
      drs_side_t sd;
      logic [STAGE_W-1:0] s;
      logic [3:0] ln;
      logic [15:0] imag;
      logic [15:0] iang;
      logic [15:0] umag;
      logic [15:0] uang;
      logic [15:0] dif;
      logic [15:0] dabs;
      logic [17:0] sum;
      logic [31:0] acc;
      logic pick;
      logic blk;
      logic [NUM_OUTS-1:0] no;
      logic [NUM_OUTS-1:0] old;
      a = st_reg.ap_addr;
      off = '0;
      rv = '0;
      gw = '0;
      s = st_reg.stg;
      g = st_reg.gen[s];
      s0 = drs_set0_t'(st_reg.w0);
      s1 = drs_set1_t'(st_reg.w1);
      s2 = drs_set2_t'(ram_rdata);
      sd = st_reg.meas.side1;
      ln = LN_ON;
      imag = '0;
      iang = '0;
      umag = '0;
      uang = '0;
      dif = '0;
      dabs = '0;
      sum = '0;
      acc = '0;
      pick = 1'b0;
      blk = 1'b0;
      no = '0;
      old = st_reg.outs[s];
      st_next = st_reg;
      st_next.evt.valid = 1'b0;
      ram_we = 1'b0;
      ram_waddr = '0;
      ram_raddr = '0;

      if (st_reg.ms_div >= 32'(MS_CYCLES - 1)) begin
         st_next.ms_div = '0;
         st_next.stamp = st_reg.stamp + 32'h1;
      end else begin
         st_next.ms_div = st_reg.ms_div + 32'h1;
      end

      // read mux, registered into hrdata during the last wait cycle
      if (a == ADDR_CTRL) begin
         rv = st_reg.ctrl;
      end else if (a == ADDR_NOMINAL) begin
         rv = st_reg.nominal;
      end else if (a == ADDR_STATUS) begin
         rv = 32'(st_reg.outs);
      end else if (a == ADDR_TIME) begin
         rv = st_reg.stamp;
      end else if (a >= ADDR_GEN && a < ADDR_GEN + GEN_SPAN) begin
         off = a - ADDR_GEN;
         rv = st_reg.gen[off[WORD_LSB +: STAGE_W]];
      end else if (a >= ADDR_CNT && a < ADDR_CNT + CNT_SPAN) begin
         off = a - ADDR_CNT;
         if (int'(off[WORD_LSB +: 2]) < NUM_OUTS) begin
            rv = st_reg.cnt[off[CNT_STAGE_LSB +: STAGE_W]][off[WORD_LSB +: 2]];
         end
      end else if (a >= ADDR_PRE && a < ADDR_PRE + PRE_SPAN) begin
         off = a - ADDR_PRE;
         rv = {16'h0000, st_reg.pre[off[WORD_LSB +: STAGE_W]]};
      end else if (a >= ADDR_SET && a < ADDR_SET + SET_SPAN) begin
         rv = ram_rdata;
      end
      off = a - ADDR_SET;
      ram_raddr = off[WORD_LSB +: MEM_AW];

      // bus writes in the data phase; unmapped addresses are ignored
      if (st_reg.ap_valid && st_reg.ap_write) begin
         if (a == ADDR_CTRL) begin
            st_next.ctrl = hwdata_i & CTRL_MASK;
         end else if (a == ADDR_NOMINAL) begin
            st_next.nominal = hwdata_i;
         end else if (a >= ADDR_GEN && a < ADDR_GEN + GEN_SPAN) begin
            off = a - ADDR_GEN;
            gw = drs_gen_t'(hwdata_i);
            if (!st_reg.ctrl[CTRL_ALLOW_LN]) begin
               gw.ln = st_reg.gen[off[WORD_LSB +: STAGE_W]].ln;
            end
            st_next.gen[off[WORD_LSB +: STAGE_W]] = gw;
         end else if (a >= ADDR_SET && a < ADDR_SET + SET_SPAN) begin
            off = a - ADDR_SET;
            ram_we = 1'b1;
            ram_waddr = off[WORD_LSB +: MEM_AW];
         end
      end

      // read data phase: wait for a free ram port, then latch
      if (st_reg.ap_valid && !st_reg.ap_write) begin
         case (st_reg.rd_ph)
            2'h0: begin
               if (st_reg.fsm == SEQ_IDLE && !meas_valid_i) begin
                  st_next.rd_ph = 2'h1;
               end
            end
            2'h1: begin
               st_next.rdata = rv;
               st_next.rd_ph = 2'h2;
            end
            default: begin
            end
         endcase
      end
      if (bus_ready) begin
         st_next.ap_valid = hsel_i && hready_i && htrans_i[1];
         st_next.ap_write = hwrite_i;
         st_next.ap_addr = haddr_i[11:0];
         st_next.rd_ph = 2'h0;
      end

      // sequencer walks the stages once per update
      case (st_reg.fsm)
         SEQ_IDLE: begin
            if (meas_valid_i) begin
               st_next.meas = meas_i;
               st_next.blk = block_i;
               st_next.sg = sg_sel_i;
               st_next.stg = '0;
               st_next.fsm = SEQ_RD0;
            end
         end
         SEQ_RD0: begin
            ram_raddr = {st_reg.stg, st_reg.sg, 2'h0};
            st_next.fsm = SEQ_RD1;
         end
         SEQ_RD1: begin
            ram_raddr = {st_reg.stg, st_reg.sg, 2'h1};
            st_next.w0 = ram_rdata;
            st_next.fsm = SEQ_RD2;
         end
         SEQ_RD2: begin
            ram_raddr = {st_reg.stg, st_reg.sg, 2'h2};
            st_next.w1 = ram_rdata;
            st_next.fsm = SEQ_EVAL;
         end
         SEQ_EVAL: begin
            if (g.side == SIDE_2) begin
               sd = st_reg.meas.side2;
            end
            case (g.i_src)
               ISRC_SENS: begin
                  imag = pick_mag(g.mag, sd.s_rms, sd.s_trms, sd.s_pp);
                  iang = sd.s_ang;
               end
               ISRC_CALC: begin
                  imag = sd.calc;
                  iang = sd.calc_ang;
               end
               default: begin
                  imag = pick_mag(g.mag, sd.c_rms, sd.c_trms, sd.c_pp);
                  iang = sd.c_ang;
               end
            endcase
            case (g.u_src)
               USRC_CALC: begin
                  umag = st_reg.meas.u_calc;
                  uang = st_reg.meas.u_calc_ang;
               end
               USRC_U3: begin
                  umag = st_reg.meas.u3;
                  uang = st_reg.meas.u3_ang;
               end
               USRC_U4: begin
                  umag = st_reg.meas.u4;
                  uang = st_reg.meas.u4_ang;
               end
               default: begin
                  umag = st_reg.meas.u_meas;
                  uang = st_reg.meas.u_meas_ang;
               end
            endcase
            if (g.pol == POL_INV) begin
               uang = uang + ANGLE_HALF;
            end
            ln = st_reg.ctrl[CTRL_ALLOW_LN] ? g.ln : LN_ON;
            dif = iang - uang - s1.offset;
            dabs = dif[15] ? 16'(-dif) : dif;
            pick = imag > st_reg.nominal[15:0] / SQUELCH_DIV
                   && umag > st_reg.nominal[31:16] / SQUELCH_DIV
                   && dabs <= s1.half_width
                   && imag >= s0.i_set && umag >= s0.u_set;
            blk = st_reg.blk[s] || ln == LN_BLOCKED || ln == LN_TEST_BLK;
            no[OUT_START] = pick && !blk;
            no[OUT_BLOCK] = pick && blk;
            if (no[OUT_START]) begin
               case (s2.mode)
                  MODE_DT: begin
                     acc = st_reg.acc[s] + UPDATE_MS;
                     no[OUT_TRIP] = acc >= {16'h0000, s2.delay};
                  end
                  MODE_IDMT: begin
                     // larger current fills faster, so time falls as current rises
                     acc = st_reg.acc[s] + {16'h0000, imag};
                     no[OUT_TRIP] = acc >= {16'h0000, s0.i_set} * {16'h0000, s2.delay};
                  end
                  default: begin
                     no[OUT_TRIP] = 1'b1;
                  end
               endcase
            end
            if (st_reg.ctrl[CTRL_FORCE_EN] && g.force_code != FORCE_NORMAL) begin
               no = '0;
               acc = '0;
               case (g.force_code)
                  FORCE_START, FORCE_UE_START, FORCE_CP_START: no[OUT_START] = 1'b1;
                  FORCE_TRIP, FORCE_UE_TRIP, FORCE_CP_TRIP: begin
                     no[OUT_START] = 1'b1;
                     no[OUT_TRIP] = 1'b1;
                  end
                  FORCE_BLOCKED: no[OUT_BLOCK] = 1'b1;
                  default: begin
                  end
               endcase
            end
            if (ln == LN_OFF) begin
               no = '0;
               acc = '0;
            end
            st_next.acc[s] = acc;
            // average of the four oldest history entries
            for (int i = LAG_N - 1; i < HIST_N; i++) begin
               sum = sum + {2'b00, st_reg.hist[s][i]};
            end
            if ((no[OUT_START] && !old[OUT_START]) || (no[OUT_TRIP] && !old[OUT_TRIP])) begin
               st_next.pre[s] = sum[WIN_SHIFT +: 16];
            end
            st_next.hist[s] = {st_reg.hist[s][HIST_N-2:0], imag};
            for (int k = 0; k < NUM_OUTS; k++) begin
               if (no[k] && !old[k]) begin
                  st_next.cnt[s][k] = st_reg.cnt[s][k] + 32'h1;
               end
            end
            if (no != old) begin
               st_next.evt.valid = 1'b1;
               st_next.evt.stage = s;
               st_next.evt.on = no & ~old;
               st_next.evt.off = old & ~no;
               st_next.evt.stamp = st_reg.stamp;
            end
            st_next.outs[s] = no;
            if (int'(s) == NUM_STAGES - 1) begin
               st_next.fsm = SEQ_IDLE;
            end else begin
               st_next.stg = s + 1'b1;
               st_next.fsm = SEQ_RD0;
            end
         end
         default: begin
            st_next.fsm = SEQ_IDLE;
         end
      endcase
   end

   // single state register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_reg <= '0;
         st_reg.fsm <= SEQ_IDLE;
         st_reg.ctrl <= CTRL_RESET;
         st_reg.nominal <= NOMINAL_RESET;
         st_reg.gen <= {NUM_STAGES{GEN_RESET}};
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   always_comb begin
      for (int i = 0; i < NUM_STAGES; i++) begin
         start_o[i] = st_reg.outs[i][OUT_START];
         trip_o[i] = st_reg.outs[i][OUT_TRIP];
         blocked_o[i] = st_reg.outs[i][OUT_BLOCK];
      end
   end

   assign hrdata_o = st_reg.rdata;
   assign hreadyout_o = bus_ready;
   assign hresp_o = 1'b0;
   assign event_o = st_reg.evt;
endmodule : drs_top

// ---- drs_checker.sv ----
`timescale 1ns/1ps
module drs_checker
   import drs_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic meas_valid_i,
   input wire logic [NUM_STAGES-1:0] start_o,
   input wire logic [NUM_STAGES-1:0] trip_o,
   input wire logic [NUM_STAGES-1:0] blocked_o,
   input wire drs_event_t event_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_out_evt; $changed({start_o, trip_o, blocked_o}) |-> event_o.valid; endproperty
   a_out_evt: assert property (p_out_evt) else $error("output moved with no event");
   property p_on_off; event_o.valid |-> (event_o.on & event_o.off) == 3'h0; endproperty
   a_on_off: assert property (p_on_off) else $error("event both on and off");
   property p_on_start;
      event_o.valid && event_o.stage == 2'h0 |-> event_o.on[0] == $rose(start_o[0]);
   endproperty
   a_on_start: assert property (p_on_start) else $error("start on bit wrong");
   property p_trip_start; (trip_o & ~start_o) == 4'h0; endproperty
   a_trip_start: assert property (p_trip_start) else $error("trip without start");
   property p_blk; (start_o & blocked_o) == 4'h0; endproperty
   a_blk: assert property (p_blk) else $error("start while blocked");
   property p_upd;
      event_o.valid |-> $past(meas_valid_i, 5) || $past(meas_valid_i, 9) ||
         $past(meas_valid_i, 13) || $past(meas_valid_i, 17);
   endproperty
   a_upd: assert property (p_upd) else $error("event off the update slots");
   property p_stage; event_o.valid && $past(meas_valid_i, 5) |-> event_o.stage == 2'h0; endproperty
   a_stage: assert property (p_stage) else $error("first slot not stage 0");
   property p_inst; $rose(trip_o[0]) && $rose(start_o[0]) |-> event_o.on[1:0] == 2'b11; endproperty
   a_inst: assert property (p_inst) else $error("start and trip split");
endmodule : drs_checker
bind drs_top drs_checker chk (.clk_i, .reset_n_i, .meas_valid_i, .start_o, .trip_o,
   .blocked_o, .event_o);

// ---- drs_front.sv ----
`timescale 1ns/1ps
module drs_front
   import drs_pkg::*;
#(
   parameter int PERIOD = 50
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic en_i,
   input wire logic [15:0] cur_i,
   input wire logic [15:0] volt_i,
   input wire logic [15:0] ang_i,
   output drs_meas_t meas_o,
   output logic meas_valid_o
);
   logic [15:0] cnt;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt <= 16'h0;
         meas_valid_o <= 1'b0;
      end else begin
         meas_valid_o <= en_i && cnt == 16'h0;
         cnt <= (cnt == 16'(PERIOD - 1)) ? 16'h0 : cnt + 16'h1;
      end
   end
   // every current source shows one level, voltage angle is the zero reference
   // third voltage input stays at zero so a wrong source pick shows up
   assign meas_o = {{2{{7{cur_i}}, {3{ang_i}}}}, {2{volt_i, 16'h0000}}, 32'h0, volt_i, 16'h0000};
endmodule : drs_front

// ---- drs_top_tb.sv ----
`timescale 1ns/1ps
module drs_top_tb;
   import drs_pkg::*;
   logic clk_i = 0, reset_n_i = 0, hsel = 0, hwrite = 0, en = 0, hro, hresp, mv;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = '0;
   logic [15:0] cur = '0, volt = '0, ang = '0;
   logic [3:0] blk = '0, st, tr, bl;
   logic [2:0] sg = '0;
   drs_meas_t meas;
   drs_event_t ev;
   int err_count = 0, samples_checked = 0, cyc = 0, i;
   // current, voltage, angle, block, then expected {blocked, trip, start}
   logic [63:0] rows [5] = '{64'h0080_0080_0000_0_0ff, 64'h0080_0008_0000_0_000,
      64'h0080_0080_8000_0_000, 64'h0001_0080_0000_0_000, 64'h0080_0080_0000_f_f00};
   always #20 clk_i = ~clk_i;
   drs_front #(.PERIOD(50)) front (.clk_i, .reset_n_i, .en_i(en), .cur_i(cur), .volt_i(volt),
      .ang_i(ang), .meas_o(meas), .meas_valid_o(mv));
   drs_top #(.MS_CYCLES(10)) uut (.clk_i, .reset_n_i, .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hro),
      .hrdata_o(hrdata), .hreadyout_o(hro), .hresp_o(hresp), .meas_i(meas), .meas_valid_i(mv),
      .block_i(blk), .sg_sel_i(sg), .start_o(st), .trip_o(tr), .blocked_o(bl), .event_o(ev));
   // one single word transfer, waits on hready in both phases
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      do @(posedge clk_i); while (hro !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_i); while (hro !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // let n updates pass, then all four stages settle
   task automatic upd(input int n);
      repeat (n) @(posedge mv);
      repeat (20) @(posedge clk_i);
   endtask : upd
   // wait for a stage 0 event, bounded so a missing one falls to the compare
   task automatic wait_ev0;
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(ev.valid === 1'b1 && ev.stage === 2'h0) && n < 200);
   endtask : wait_ev0
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   // hang guard, far above the under two thousand cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      bus(0, 12'h000, 0);
      chk(rd, CTRL_RESET);
      bus(0, 12'h004, 0);
      chk(rd, NOMINAL_RESET);
      bus(0, 12'h010, 0);
      chk(rd, GEN_RESET);
      bus(0, 12'hffc, 0);
      chk(rd, 0);
      // all groups instant except group 1, definite time of 10 ms
      for (i = 0; i < 32; i++) begin
         bus(1, 12'h200 + 12'(i * 16), 32'h0010_0040);
         bus(1, 12'h204 + 12'(i * 16), 32'h2000_0000);
         bus(1, 12'h208 + 12'(i * 16), (i % 8 == 1) ? 32'h000a_0001 : 32'h0);
      end
      en <= 1'b1;
      for (i = 0; i < 5; i++) begin
         {cur, volt, ang, blk} <= rows[i][63:12];
         upd(2);
         chk({bl, tr, st}, rows[i][11:0]);
         $display("row %0d done", i);
      end
      for (i = 0; i < 3; i++) begin
         bus(0, 12'h040 + 12'(i * 4), 0);
         chk(rd, 1);
      end
      cur <= 16'h0;
      blk <= 4'h0;
      upd(2);
      cur <= 16'h80;
      wait_ev0();
      chk(ev.on, 3'b011);
      rd = ev.stamp;
      cur <= 16'h0;
      // the off event comes exactly one 5 ms update later
      wait_ev0();
      chk(ev.stamp - rd, 32'(UPDATE_MS_INT));
      // window is updates 4..7 back: row 4, row 3 twice, row 2
      bus(0, 12'h080, 0);
      chk(rd, (32'h80 + 32'h1 + 32'h1 + 32'h80) / WIN_N);
      upd(2);
      sg <= 3'h1;
      cur <= 16'h80;
      upd(1);
      chk({tr, st}, 8'h0f);
      upd(3);
      chk({tr, st}, 8'hff);
      sg <= 3'h0;
      ang <= 16'h8000;
      bus(1, 12'h010, 32'h0111_1201);
      upd(2);
      chk(st[0], 1);
      // third voltage input reads zero, so no pick-up from it
      bus(1, 12'h010, 32'h0111_3201);
      upd(2);
      chk(st[0], 0);
      cur <= 16'h0;
      bus(1, 12'h000, 32'h3);
      bus(1, 12'h010, 32'h0111_1121);
      upd(2);
      chk({tr[0], st[0]}, 2'b11);
      bus(1, 12'h010, 32'h0111_1125);
      upd(2);
      chk({bl[0], tr[0], st[0]}, 0);
      $display("hand tests done");
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({bl, tr, st}, 0);
      // second release: control must be back at its reset value
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      bus(0, 12'h000, 0);
      chk(rd, CTRL_RESET);
      report_and_stop();
   end
endmodule : drs_top_tb
